/* File: rtl/sup_pkg.sv */
// Constants and carrier types for the supply/watchdog supervisor.
// Assumes a 250 MHz core clock; all times are converted to cycles here.
package sup_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int PORST_MS = 200;
  localparam int PORST_CYC = PORST_MS * CLK_MHZ * 1000;
  localparam int WD_LONG_MS = 1400;
  localparam int WD_MID_MS = 600;
  localparam int WD_SHORT_MS = 200;
  localparam int WD_LONG_CYC = WD_LONG_MS * CLK_MHZ * 1000;
  localparam int WD_MID_CYC = WD_MID_MS * CLK_MHZ * 1000;
  localparam int WD_SHORT_CYC = WD_SHORT_MS * CLK_MHZ * 1000;
  localparam int NVW_MS = 5;
  localparam int NVW_CYC = NVW_MS * CLK_MHZ * 1000;
  localparam int CNT_W = 32;
  // ----------------------------------------
  // Opcodes and register layout
  // ----------------------------------------
  localparam logic [7:0] OP_UNLOCK = 8'h06;
  localparam logic [7:0] OP_LOCK = 8'h04;
  localparam logic [7:0] OP_PWRITE = 8'h01;
  localparam logic [7:0] OP_PREAD = 8'h05;
  localparam logic [7:0] OP_TRIP_A = 8'h03;
  localparam logic [7:0] OP_TRIP_B = 8'h02;
  localparam logic [7:0] TRIP_MID = 8'h00;
  localparam logic [7:0] TRIP_RAISE = 8'h01;
  localparam logic [7:0] TRIP_NATIVE = 8'h03;
  localparam int SEL_HI_BIT = 4;
  localparam int SEL_LO_BIT = 3;
  localparam logic [1:0] SEL_RESET = 2'h0;
  localparam logic [1:0] SEL_OFF = 2'h3;
  localparam logic [4:0] BITS_WRITE = 5'h10;
  localparam logic [4:0] BITS_TRIP = 5'h18;

  // SPI pin group after synchronisation
  typedef struct packed {
    logic sel_n;
    logic sck;
    logic si;
  } spi_pins_t;

  typedef enum logic [1:0] {TRIP_IDLE, TRIP_ARMED} trip_state_t;
endpackage : sup_pkg

/* File: rtl/spi_watchdog_supervisor.sv */
// Supply reset, watchdog and SPI mode-0 command slave in one block.
// Assumes SPI pins and the supply comparator are asynchronous to core_clk.
// Function
// RULE1: Power-up reset held until supply good 200ms
// RULE2: Low supply asserts reset, release after 200ms
// RULE3: Select falling edge restarts watchdog count
// RULE4: Period bits select 1.4s/600ms/200ms/off
// RULE5: Eight-bit register, only bits 4,3 meaningful
// RULE6: Host writes zeros outside bits 4,3
// RULE7: Write needs unlock first, then write
// RULE8: Opcode 06h unlocks, 04h locks
// RULE9: Unlock clears at power-up and write end
// RULE10: Write opcode 01h followed by one data byte
// RULE11: Read opcode 05h shifts register out
// RULE12: Read during write returns high on SO
// RULE13: Change applies only on correct select count
// RULE14: MSB first, sampled on rising SCK
// RULE15: SO changes on falling SCK edge
// RULE16: Static serial logic, SCK may pause
// RULE17: Standby after power-up, SO high impedance
// RULE18: Trip raise: 03 00 01 then 02 00 01
// RULE19: Trip native: same but final byte 03h
// RULE20: Reset low on low supply or watchdog expiry
// RULE21: Deselected: SO released, SCK SI ignored
// RULE22: Locked or miscounted write is discarded
// RULE23: Write busy lasts a parameter, then applies
`timescale 1ns/10ps
`default_nettype none
module spi_watchdog_supervisor
  import sup_pkg::*;
#(
  parameter int PORST_CYCLES = PORST_CYC,
  parameter int WD_LONG = WD_LONG_CYC,
  parameter int WD_MID = WD_MID_CYC,
  parameter int WD_SHORT = WD_SHORT_CYC,
  parameter int NVW_CYCLES = NVW_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic select_kick_in,
  input wire logic sck_in,
  input wire logic si_in,
  input wire logic supply_low_in,
  input wire logic trip_prog_enable,
  output logic so_out,
  output logic so_oe_n,
  output logic reset_out,
  output logic reset_oe_n,
  output logic trip_raise_pulse,
  output logic trip_native_pulse,
  output logic nv_busy
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  spi_pins_t pins_s1_r, pins_r, pins_d_r;
  logic low_s1_r, low_r;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pins_s1_r <= '{sel_n: 1'b1, sck: 1'b0, si: 1'b0};
      pins_r <= '{sel_n: 1'b1, sck: 1'b0, si: 1'b0};
      pins_d_r <= '{sel_n: 1'b1, sck: 1'b0, si: 1'b0};
      low_s1_r <= 1'b1;
      low_r <= 1'b1;
    end else begin
      pins_s1_r <= '{sel_n: select_kick_in, sck: sck_in, si: si_in};
      pins_r <= pins_s1_r;
      pins_d_r <= pins_r;
      low_s1_r <= supply_low_in;
      low_r <= low_s1_r;
    end
  end

  // Edges compare the second and third stages; the first stage is never read here
  wire logic sel_fall = pins_d_r.sel_n & ~pins_r.sel_n;
  wire logic sel_rise = ~pins_d_r.sel_n & pins_r.sel_n;
  wire logic active = ~pins_r.sel_n & ~pins_d_r.sel_n;
  // RULE14 rising SCK sample
  wire logic sck_rise = active & pins_r.sck & ~pins_d_r.sck;
  // RULE15 falling SCK shift
  wire logic sck_fall = active & ~pins_r.sck & pins_d_r.sck;

  // ----------------------------------------
  // Supply-good delay (power-on and brownout)
  // ----------------------------------------
  logic [CNT_W-1:0] por_cnt_r;
  logic supply_ok_r;
  // RULE1 RULE2 continuous 200ms good supply
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      por_cnt_r <= '0;
      supply_ok_r <= 1'b0;
    end else if (low_r) begin
      por_cnt_r <= '0;
      supply_ok_r <= 1'b0;
    end else if (por_cnt_r == CNT_W'(PORST_CYCLES - 1)) begin
      supply_ok_r <= 1'b1;
    end else begin
      por_cnt_r <= por_cnt_r + 1'b1;
    end
  end

  // ----------------------------------------
  // Timeout register and watchdog
  // ----------------------------------------
  logic [1:0] period_sel_r;
  logic [CNT_W-1:0] wd_cnt_r;
  logic wd_expired_r;

  function automatic logic [CNT_W-1:0] wd_limit(input logic [1:0] sel);
    // RULE4 period decode
    unique case (sel)
      2'h0: wd_limit = CNT_W'(WD_LONG);
      2'h1: wd_limit = CNT_W'(WD_MID);
      2'h2: wd_limit = CNT_W'(WD_SHORT);
      2'h3: wd_limit = '0;
    endcase
  endfunction : wd_limit

  wire logic wd_on = (period_sel_r != SEL_OFF);
  // Watchdog only runs once the supply reset has released
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wd_cnt_r <= '0;
      wd_expired_r <= 1'b0;
    // RULE3 kick restarts count
    end else if (sel_fall | ~wd_on | ~supply_ok_r) begin
      wd_cnt_r <= '0;
      wd_expired_r <= 1'b0;
    // Compared with >= so a shorter period chosen mid-count expires at once
    end else if (wd_cnt_r >= wd_limit(period_sel_r) - 1'b1) begin
      wd_expired_r <= 1'b1;
    end else begin
      wd_cnt_r <= wd_cnt_r + 1'b1;
    end
  end

  // RULE20 reset on low supply or expiry
  wire logic reset_assert = ~supply_ok_r | wd_expired_r;
  assign reset_out = 1'b0;
  assign reset_oe_n = ~reset_assert;

  // ----------------------------------------
  // Serial command decoder
  // ----------------------------------------
  logic [4:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] opcode_r;
  logic [7:0] data_r;
  logic unlock_r;
  logic so_r;
  logic so_en_r;
  logic [1:0] pend_sel_r;
  logic [CNT_W-1:0] nvw_cnt_r;
  trip_state_t trip_st_r;
  logic [7:0] pend_b3_r;

  wire logic [7:0] shift_nxt = {shift_r[6:0], pins_r.si};
  wire logic byte_done = sck_rise & (bit_cnt_r[2:0] == 3'h7);
  wire logic op_done = byte_done & (bit_cnt_r[4:3] == 2'h0);
  // RULE5 RULE11 reserved bits read zero
  wire logic [7:0] reg_view = {3'h0, period_sel_r[1], period_sel_r[0], 3'h0};
  wire logic [7:0] rd_byte = nv_busy ? 8'hff : reg_view;
  // RULE13 RULE22 commit only at exactly 16 bits
  // Busy writes are refused so pend_sel_r cannot change mid-cycle
  wire logic write_ok = sel_rise & (opcode_r == OP_PWRITE) & (bit_cnt_r == BITS_WRITE) & unlock_r & ~nv_busy;
  wire logic trip_frame = sel_rise & (bit_cnt_r == BITS_TRIP) & (data_r == TRIP_MID);
  wire logic nvw_end = nv_busy & (nvw_cnt_r == CNT_W'(NVW_CYCLES - 1));

  // RULE16 position kept across SCK pauses
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_cnt_r <= '0;
      shift_r <= '0;
      opcode_r <= '0;
      data_r <= '0;
      pend_b3_r <= '0;
    end else if (sel_fall) begin
      bit_cnt_r <= '0;
      opcode_r <= '0;
    end else if (sck_rise) begin
      shift_r <= shift_nxt;
      if (bit_cnt_r != 5'h1f) begin
        bit_cnt_r <= bit_cnt_r + 1'b1;
      end
      if (op_done) begin
        opcode_r <= shift_nxt;
      end else if (byte_done && bit_cnt_r[4:3] == 2'h1) begin
        data_r <= shift_nxt;
      end else if (byte_done && bit_cnt_r[4:3] == 2'h2) begin
        pend_b3_r <= shift_nxt;
      end
    end
  end

  // RULE8 RULE9 unlock latch
  // An unlock in the cycle that ends a write wins over the auto-clear
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      unlock_r <= 1'b0;
    end else if (op_done && shift_nxt == OP_UNLOCK) begin
      unlock_r <= 1'b1;
    end else if (nvw_end) begin
      unlock_r <= 1'b0;
    end else if (op_done && shift_nxt == OP_LOCK) begin
      unlock_r <= 1'b0;
    end
  end

  // RULE7 RULE10 RULE23 write cycle with busy flag
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      nv_busy <= 1'b0;
      nvw_cnt_r <= '0;
      pend_sel_r <= SEL_RESET;
      period_sel_r <= SEL_RESET;
    end else if (write_ok) begin
      nv_busy <= 1'b1;
      nvw_cnt_r <= '0;
      pend_sel_r <= {data_r[SEL_HI_BIT], data_r[SEL_LO_BIT]};
    end else if (nvw_end) begin
      nv_busy <= 1'b0;
      period_sel_r <= pend_sel_r;
    end else if (nv_busy) begin
      nvw_cnt_r <= nvw_cnt_r + 1'b1;
    end
  end

  // RULE11 RULE12 RULE15 read data on falling SCK
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      so_r <= 1'b0;
      so_en_r <= 1'b0;
    end else if (pins_r.sel_n) begin
      so_en_r <= 1'b0;
    end else if (sck_fall && opcode_r == OP_PREAD && bit_cnt_r[4:3] == 2'h1) begin
      so_en_r <= 1'b1;
      so_r <= rd_byte[3'h7 - bit_cnt_r[2:0]];
    end else if (sck_fall && opcode_r == OP_PREAD && bit_cnt_r == BITS_WRITE) begin
      so_r <= rd_byte[0];
    end
  end
  // RULE17 RULE21 SO released while deselected
  assign so_out = so_r;
  assign so_oe_n = ~(so_en_r & ~pins_r.sel_n);

  // RULE18 RULE19 two-frame trip programming
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trip_st_r <= TRIP_IDLE;
      trip_raise_pulse <= 1'b0;
      trip_native_pulse <= 1'b0;
    end else begin
      trip_raise_pulse <= 1'b0;
      trip_native_pulse <= 1'b0;
      if (sel_rise) begin
        unique case (trip_st_r)
          TRIP_IDLE: begin
            if (trip_frame && opcode_r == OP_TRIP_A && pend_b3_r == TRIP_RAISE) begin
              trip_st_r <= TRIP_ARMED;
            end
          end
          TRIP_ARMED: begin
            trip_st_r <= TRIP_IDLE;
            if (trip_frame && opcode_r == OP_TRIP_B && trip_prog_enable) begin
              trip_raise_pulse <= (pend_b3_r == TRIP_RAISE);
              trip_native_pulse <= (pend_b3_r == TRIP_NATIVE);
            end
          end
          default: trip_st_r <= TRIP_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // RULE2 low supply reset
  chk_reset_low_supply: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE2
    low_r |=> ##1 !reset_oe_n) else $error("reset not asserted on low supply");
  // RULE22 locked write dropped
  chk_write_needs_unlock: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE22
    (sel_rise && !unlock_r) |=> !$rose(nv_busy)) else $error("locked write started");
  // RULE12 busy read high
  chk_busy_reads_high: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE12
    (nv_busy && !so_oe_n && $past(sck_fall) && opcode_r == OP_PREAD) |-> so_out)
    else $error("read during write not high");
  // RULE21 deselect releases SO
  chk_deselect_release: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE21
    pins_r.sel_n |=> (so_oe_n && !so_en_r)) else $error("SO driven while deselected");
  // RULE9 write end relocks
  chk_unlock_clears: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE9
    (nvw_end && !(op_done && shift_nxt == OP_UNLOCK)) |=> !unlock_r)
    else $error("unlock kept after write");
  // RULE3 kick restarts count
  chk_kick_restarts: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE3
    sel_fall |=> wd_cnt_r == '0) else $error("kick did not restart");
  // RULE4 off never expires
  chk_wd_off_quiet: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE4
    (period_sel_r == SEL_OFF) |=> !wd_expired_r) else $error("disabled watchdog expired");
  // RULE20 expiry drives reset
  chk_expiry_resets: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE20
    (wd_on && supply_ok_r && !sel_fall && wd_cnt_r == wd_limit(period_sel_r) - 1'b1) |=> !reset_oe_n)
    else $error("expiry without reset");
endmodule : spi_watchdog_supervisor
`default_nettype wire

/* File: bench/host_model.sv */
// Behavioural SPI mode-0 host for the supervisor block.
// Assumes core_clk pacing: one SCK half period is six core cycles (48 ns period).
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic core_clk,
  input wire logic so_out,
  input wire logic so_oe_n,
  output logic sel_n,
  output logic sck,
  output logic si
);
  initial begin
    sel_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  // MSB first, optional stall mid-frame
  // A frame of zero bits is a bare select pulse, which serves as a watchdog kick.
  task automatic xfer(input int nbits, input logic [23:0] dat, input int stall, output logic [7:0] rx);
    rx = 8'h00;
    @(posedge core_clk) sel_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    for (int i = nbits - 1; i >= 0; i--) begin
      si <= dat[i];
      repeat (6) @(posedge core_clk);
      sck <= 1'b1;
      // Undriven SO has no pull, so it is seen inverted to expose early sampling
      rx = {rx[6:0], so_oe_n ? ~so_out : so_out};
      repeat (6) @(posedge core_clk);
      sck <= 1'b0;
      if (i == 4) repeat (stall) @(posedge core_clk);
    end
    repeat (6) @(posedge core_clk);
    sel_n <= 1'b1;
    si <= ~si;
    repeat (12) @(posedge core_clk);
    // Leave the edge's time step so callers read settled outputs
    #1;
  endtask : xfer
endmodule : host_model
`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking bench for the supervisor: reset timing, register access, trip frames, watchdog.
// Assumes the host model paces SPI frames from core_clk; counts are shortened by parameters.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import sup_pkg::*;
  localparam int PORST = 300;
  localparam int WDS = 1000;
  logic core_clk, sys_rst, supply_low_in, trip_prog_enable, sel_n, sck, si;
  logic so_out, so_oe_n, reset_out, reset_oe_n, trip_raise_pulse, trip_native_pulse, nv_busy;
  // Pull-up on the open-drain reset line
  wire logic reset_pin_n = reset_oe_n ? 1'b1 : reset_out;
  logic [7:0] v;
  int num_errors = 0;
  int checks_done = 0;
  int raise_cnt = 0;
  int native_cnt = 0;
  spi_watchdog_supervisor #(.PORST_CYCLES(PORST), .WD_LONG(2000), .WD_MID(1500), .WD_SHORT(WDS),
    .NVW_CYCLES(400)) u_spi_watchdog_supervisor (.core_clk(core_clk), .sys_rst(sys_rst),
    .select_kick_in(sel_n), .sck_in(sck), .si_in(si), .supply_low_in(supply_low_in),
    .trip_prog_enable(trip_prog_enable), .so_out(so_out), .so_oe_n(so_oe_n), .reset_out(reset_out),
    .reset_oe_n(reset_oe_n), .trip_raise_pulse(trip_raise_pulse), .trip_native_pulse(trip_native_pulse),
    .nv_busy(nv_busy));
  host_model u_host_model (.core_clk(core_clk), .so_out(so_out), .so_oe_n(so_oe_n), .sel_n(sel_n), .sck(sck),
    .si(si));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Pulses last one cycle, so they are counted as they pass, away from the launching edge
  always @(negedge core_clk) begin
    if (trip_raise_pulse === 1'b1) raise_cnt++;
    if (trip_native_pulse === 1'b1) native_cnt++;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic frame(input int n, input logic [23:0] d);
    u_host_model.xfer(n, d, 0, v);
  endtask : frame
  task automatic rd();
    u_host_model.xfer(16, {8'h00, OP_PREAD, 8'h00}, 0, v);
  endtask : rd
  task automatic print_verdict();
    $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task automatic t_por();
    cyc(PORST - 10);
    chk(reset_pin_n, 1'b0);
    chk(so_oe_n, 1'b1);
    cyc(20);
    chk(reset_pin_n, 1'b1);
  endtask : t_por
  task automatic t_locked();
    rd();
    chk(v, 8'h00);
    frame(16, {8'h00, OP_PWRITE, 8'h18});
    chk(nv_busy, 1'b0);
    frame(8, {16'h0, OP_UNLOCK});
    frame(8, {16'h0, OP_LOCK});
    frame(16, {8'h00, OP_PWRITE, 8'h18});
    chk(nv_busy, 1'b0);
    rd();
    chk(v, 8'h00);
  endtask : t_locked
  task automatic t_write();
    int n;
    u_host_model.xfer(8, {16'h0, OP_UNLOCK}, 20, v);
    frame(16, {8'h00, OP_PWRITE, 8'h10});
    chk(nv_busy, 1'b1);
    rd();
    chk(v, 8'hff);
    n = 0;
    while (nv_busy !== 1'b0 && n < 400) begin
      cyc(1);
      n++;
    end
    chk(nv_busy, 1'b0);
    rd();
    chk(v, 8'h10);
    frame(16, {8'h00, OP_PWRITE, 8'h08});
    chk(nv_busy, 1'b0);
    frame(8, {16'h0, OP_UNLOCK});
    frame(17, {7'h00, OP_PWRITE, 8'h08, 1'b0});
    chk(nv_busy, 1'b0);
    rd();
    chk(v, 8'h10);
  endtask : t_write
  task automatic t_trip();
    @(posedge core_clk) trip_prog_enable <= 1'b1;
    frame(24, {OP_TRIP_A, TRIP_MID, TRIP_RAISE});
    chk(raise_cnt[7:0], 8'h00);
    frame(24, {OP_TRIP_B, TRIP_MID, TRIP_RAISE});
    chk(raise_cnt[7:0], 8'h01);
    frame(24, {OP_TRIP_A, TRIP_MID, TRIP_RAISE});
    frame(24, {OP_TRIP_B, TRIP_MID, TRIP_NATIVE});
    chk({raise_cnt[3:0], native_cnt[3:0]}, 8'h11);
    @(posedge core_clk) trip_prog_enable <= 1'b0;
  endtask : t_trip
  task automatic t_watch();
    for (int i = 0; i < 3; i++) begin
      frame(0, 24'h0);
      cyc(800);
      chk(reset_pin_n, 1'b1);
    end
    frame(0, 24'h0);
    @(posedge core_clk) supply_low_in <= 1'b1;
    cyc(10);
    chk(reset_pin_n, 1'b0);
    cyc(50);
    @(posedge core_clk) supply_low_in <= 1'b0;
    cyc(PORST - 10);
    chk(reset_pin_n, 1'b0);
    cyc(20);
    chk(reset_pin_n, 1'b1);
    frame(0, 24'h0);
    cyc(WDS - 30);
    chk(reset_pin_n, 1'b1);
    cyc(60);
    chk(reset_pin_n, 1'b0);
  endtask : t_watch
  task automatic t_modes();
    frame(8, {16'h0, OP_UNLOCK});
    frame(16, {8'h00, OP_PWRITE, 8'h08});
    cyc(420);
    rd();
    chk(v, 8'h08);
    frame(0, 24'h0);
    cyc(1470);
    chk(reset_pin_n, 1'b1);
    cyc(60);
    chk(reset_pin_n, 1'b0);
    frame(8, {16'h0, OP_UNLOCK});
    frame(16, {8'h00, OP_PWRITE, 8'h18});
    cyc(420);
    rd();
    chk(v, 8'h18);
    cyc(2500);
    chk(reset_pin_n, 1'b1);
    frame(8, {16'h0, OP_UNLOCK});
    @(posedge core_clk) sys_rst <= 1'b1;
    cyc(5);
    chk(reset_pin_n, 1'b0);
    @(posedge core_clk) sys_rst <= 1'b0;
    cyc(PORST + 20);
    frame(16, {8'h00, OP_PWRITE, 8'h08});
    chk(nv_busy, 1'b0);
    rd();
    chk(v, 8'h00);
  endtask : t_modes
  initial begin
    sys_rst = 1'b1;
    supply_low_in = 1'b0;
    trip_prog_enable = 1'b0;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_por();
    t_locked();
    t_write();
    t_trip();
    t_watch();
    t_modes();
    print_verdict();
  end
  // Whole sequence needs roughly 15000 cycles
  initial begin
    repeat (40000) @(posedge core_clk);
    num_errors++;
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
